//--- core/sbi_core.v
// executes skip, jump, or-literal and increment instructions of an 8-bit core
// assumes fetch supplies one instruction word per valid cycle and the file
// array returns read data combinationally for file_addr
//
// Overview of operation
// - dec_and_skip_on_null subtracts one from a file register, result to acc or file by d.
// - a zero result of dec_and_skip_on_null turns the next instruction into a no-op.
// - inc_and_skip_on_null adds one, stores by d, keeps flags and skips on a zero result.
// - unconditional_jump loads k into pc 10:0 and upper_jump_latch 4:3 into pc 12:11.
// - unconditional_jump is always taken, costs two cycles and keeps the flags.
// - or_literal_into_acc ors an 8-bit literal into acc and updates the zero flag.
// - add_one_to_reg adds one, stores by d and updates the zero flag.
// - the zero flag is set exactly when an updating instruction's result is all zeros.
`include "sbi_defines.vh"
module sbi_core
#(
   parameter PC_W = 13
)
(
   input  wire             clk_sys,
   input  wire             rst_n,
   input  wire             instr_valid,
   input  wire [13:0]      instr_word,
   input  wire [7:0]       upper_jump_latch,
   input  wire [7:0]       file_rdata,
   output wire [6:0]       file_addr,
   output reg              file_we_ff,
   output reg  [6:0]       file_waddr_ff,
   output reg  [7:0]       file_wdata_ff,
   output reg  [7:0]       acc_ff,
   output reg              zero_flag_ff,
   output reg  [PC_W-1:0]  pc_ff,
   output reg              squash_ff,
   output reg              busy_ff
);
   localparam ST_RUN  = 2'b01;
   localparam ST_NOP  = 2'b10;
   reg  [1:0]      state_ff;
   reg  [1:0]      nxt_state;
   reg  [7:0]      nxt_acc;
   reg             nxt_zero;
   reg  [PC_W-1:0] nxt_pc;
   reg             nxt_we;
   reg  [1:0]      op_sel;
   reg             is_dec_skip;
   reg             is_inc_skip;
   reg             is_add_one;
   reg             is_or_lit;
   reg             is_jump;
   wire [7:0]      alu_res;
   wire            alu_null;
   wire            to_file;

   // pc advance shared by executed and discarded slots
   function [PC_W-1:0] pc_next;
      input [PC_W-1:0] pc_cur;
      begin
         pc_next = pc_cur + {{(PC_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // six-bit opcode field match, used by all four byte-wide forms
   function op_hit;
      input [13:0] word;
      input [5:0]  code;
      begin
         op_hit = (word[13:8] == code);
      end
   endfunction

   assign file_addr = instr_word[6:0];
   assign to_file   = instr_word[`SBI_DEST_BIT];

   sbi_alu u_alu
   (
      .operand_a (is_or_lit ? acc_ff : file_rdata),
      .operand_b (instr_word[7:0]),
      .op_sel    (op_sel),
      .result    (alu_res),
      .is_null   (alu_null)
   );

   always @*
   begin
      is_dec_skip = op_hit(instr_word, `SBI_OPC_DEC_SKIP);
      is_inc_skip = op_hit(instr_word, `SBI_OPC_INC_SKIP);
      is_add_one  = op_hit(instr_word, `SBI_OPC_ADD_ONE);
      is_or_lit   = op_hit(instr_word, `SBI_OPC_OR_LIT);
      is_jump     = (instr_word[13:11] == `SBI_OPC_JUMP);
      op_sel      = 2'h0;
      if (is_inc_skip || is_add_one)
         op_sel = 2'h1;
      else if (is_dec_skip)
         op_sel = 2'h2;
      else if (is_or_lit)
         op_sel = 2'h3;
   end

   always @*
   begin
      nxt_state = state_ff;
      nxt_acc   = acc_ff;
      nxt_zero  = zero_flag_ff;
      nxt_pc    = pc_ff;
      nxt_we    = 1'b0;
      case (state_ff)
         ST_RUN:
         begin
            if (instr_valid)
            begin
               nxt_pc = pc_next(pc_ff);
               if (is_dec_skip || is_inc_skip || is_add_one)
               begin
                  // destination by d for all three step forms
                  if (to_file)
                     nxt_we = 1'b1;
                  else
                     nxt_acc = alu_res;
                  if (is_add_one)
                     nxt_zero = alu_null;
                  // skip forms leave the flags alone
                  if (!is_add_one && alu_null)
                     nxt_state = ST_NOP;
               end
               else if (is_or_lit)
               begin
                  nxt_acc  = alu_res;
                  nxt_zero = alu_null;
               end
               else if (is_jump)
               begin
                  // flags untouched; second cycle is the flushed fetch
                  nxt_pc = {upper_jump_latch[`SBI_LATCH_HI:`SBI_LATCH_LO],
                            instr_word[10:0]};
                  nxt_state = ST_NOP;
               end
            end
         end
         ST_NOP:
         begin
            // the word now on the fetch port is discarded, pc still advances
            if (instr_valid)
            begin
               nxt_pc    = pc_next(pc_ff);
               nxt_state = ST_RUN;
            end
         end
         default:
            nxt_state = ST_RUN;
      endcase
   end

   // slot sequencer: one-hot run or discard
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_RUN;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // accumulator and zero flag move only on an executed slot
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         acc_ff       <= `SBI_ACC_RST;
         zero_flag_ff <= 1'b0;
      end
      else
      begin
         acc_ff       <= nxt_acc;
         zero_flag_ff <= nxt_zero;
      end
   end

   // program counter, frozen while valid is low
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pc_ff <= `SBI_PC_RST;
      end
      else
      begin
         pc_ff <= nxt_pc;
      end
   end

   // write port: data and address follow every cycle, only the strobe qualifies
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         file_we_ff    <= 1'b0;
         file_waddr_ff <= 7'h00;
         file_wdata_ff <= 8'h00;
      end
      else
      begin
         file_we_ff    <= nxt_we;
         file_waddr_ff <= file_addr;
         file_wdata_ff <= alu_res;
      end
   end

   // squash marks the slot whose fetched word is thrown away
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         squash_ff <= 1'b0;
         busy_ff   <= 1'b0;
      end
      else
      begin
         squash_ff <= (nxt_state == ST_NOP);
         busy_ff   <= (nxt_state == ST_NOP);
      end
   end
endmodule

//--- core/sbi_defines.vh
// opcode encodings, field positions and reset values for the sbi executor
// assumes 14-bit instruction words as delivered by the fetch stage
`ifndef SBI_DEFINES_VH
`define SBI_DEFINES_VH
`define SBI_OPC_DEC_SKIP   6'h0B
`define SBI_OPC_INC_SKIP   6'h0F
`define SBI_OPC_ADD_ONE    6'h0A
`define SBI_OPC_OR_LIT     6'h38
`define SBI_OPC_JUMP       3'h5
`define SBI_NOP_WORD       14'h0000
`define SBI_ACC_RST        8'h00
`define SBI_PC_RST         13'h0000
`define SBI_DEST_BIT       7
`define SBI_LATCH_LO       3
`define SBI_LATCH_HI       4
`endif

//--- core/sbi_alu.v
// combinational step unit: plus or minus one, or literal or, with zero test
// assumes operands are stable within the cycle that reads the result
module sbi_alu
(
   input  wire [7:0] operand_a,
   input  wire [7:0] operand_b,
   input  wire [1:0] op_sel,
   output reg  [7:0] result,
   output wire       is_null
);
   always @*
   begin
      case (op_sel)
         2'h1:    result = operand_a + 8'h01;
         2'h2:    result = operand_a - 8'h01;
         2'h3:    result = operand_a | operand_b;
         default: result = operand_a;
      endcase
   end
   // 8-bit result wraps, so the zero test sees the wrapped value
   assign is_null = (result == 8'h00);
endmodule

//--- test/sbi_core_chk.sv
// port checks for sbi_core
// assumes file_rdata answers file_addr within the cycle
module sbi_core_chk #(parameter PC_W = 13) (
   input wire clk_sys, rst_n, instr_valid, file_we_ff, zero_flag_ff, squash_ff,
   input wire [13:0] instr_word,
   input wire [7:0] upper_jump_latch, file_rdata, file_wdata_ff, acc_ff,
   input wire [PC_W-1:0] pc_ff);
   timeunit 1ns / 1ps;
   wire tk = instr_valid & ~squash_ff;
   wire [5:0] op = instr_word[13:8];
   wire dk = tk & op == 6'h0B, ak = tk & op == 6'h0A, ok = tk & op == 6'h38;
   wire sk = dk | tk & op == 6'h0F, jk = tk & instr_word[13:11] == 3'h5;
   wire [7:0] res = dk ? file_rdata - 8'h01 : file_rdata + 8'h01;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   dest_val_a: assert property (sk | ak |=>
      ($past(instr_word[7]) ? file_wdata_ff : acc_ff) == $past(res)) else $error("bad st");
   skip_null_a: assert property (sk |=>
      squash_ff == ($past(res) == 8'h00)) else $error("bad skip");
   flag_keep_a: assert property (sk | jk |=> $stable(zero_flag_ff))
      else $error("bad flag");
   inc_zero_a: assert property (ak |=> zero_flag_ff == ($past(res) == 8'h00))
      else $error("bad z");
   jump_pc_a: assert property (jk |=> squash_ff &&
      pc_ff == {$past(upper_jump_latch[4:3]), $past(instr_word[10:0])}) else $error("bad pc");
   or_lit_a: assert property (ok |=>
      acc_ff == ($past(acc_ff) | $past(instr_word[7:0]))) else $error("bad or");
   or_zero_a: assert property (ok |=> zero_flag_ff == (acc_ff == 8'h00))
      else $error("bad or z");
   nop_slot_a: assert property (squash_ff & instr_valid |=>
      !squash_ff && !file_we_ff && $stable(acc_ff)) else $error("bad nop");
endmodule
bind sbi_core sbi_core_chk #(.PC_W(PC_W)) chk (.*);

//--- test/skip_branch_incdec_ops_test.sv
// bench for sbi_core, one task per instruction group
// assumes the core and its bound checker compile first
module skip_branch_incdec_ops_test;
   timeunit 1ns / 1ps;
   logic clk_sys = 1'h0, rst_n = 1'h0, instr_valid = 1'h0;
   logic [13:0] instr_word = 14'h0000;
   logic [7:0] upper_jump_latch = 8'h18, file_rdata = 8'h00;
   wire [7:0] file_wdata_ff, acc_ff;
   wire [6:0] file_addr, file_waddr_ff;
   wire [12:0] pc_ff;
   wire file_we_ff, zero_flag_ff, squash_ff, busy_ff;
   int n_fail = 0, checked = 0, cycles = 0;
   sbi_core dut (.*);
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (++cycles > 300)
         end_sim(1);
   task end_sim(input int extra);
      n_fail += extra;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task ck(input logic [15:0] got, exp);
      checked++;
      n_fail += (got !== exp);
      if (got !== exp)
         $display("BAD %0t %h %h", $time, got, exp);
   endtask
   // idle slot between words: a lowered valid freezes the core
   task step(input logic [13:0] w, input logic [7:0] rd);
      @(posedge clk_sys) {instr_valid, instr_word, file_rdata} <= {1'h1, w, rd};
      @(posedge clk_sys) instr_valid <= 1'h0;
      #1;
   endtask
   task t_alu;
      step(14'h385A, 8'h00);
      step(14'h3881, 8'h00);
      ck({acc_ff, zero_flag_ff}, {8'hDB, 1'h0});
      step(14'h0A95, 8'hFF);
      ck({file_we_ff, file_waddr_ff, file_wdata_ff}, {1'h1, 7'h15, 8'h00});
      ck(file_addr, 7'h15);
      ck(zero_flag_ff, 1'h1);
      $display("alu test done");
   endtask
   task t_skip;
      step(14'h0B90, 8'h01);
      ck({file_wdata_ff, squash_ff}, {8'h00, 1'h1});
      step(14'h38FF, 8'h00);
      step(14'h0B20, 8'h05);
      step(14'h0F20, 8'hFF);
      step(14'h0A20, 8'h00);
      ck({acc_ff, squash_ff, zero_flag_ff}, {8'h00, 1'h0, 1'h1});
      step(14'h0F90, 8'hFF);
      ck({file_we_ff, file_wdata_ff, squash_ff}, {1'h1, 8'h00, 1'h1});
      step(14'h3801, 8'h00);
      ck({acc_ff, squash_ff}, {8'h00, 1'h0});
      $display("skip test done");
   endtask
   task t_jump;
      step(14'h2923, 8'h00);
      ck({pc_ff, squash_ff, busy_ff, zero_flag_ff}, {13'h1923, 1'h1, 1'h1, 1'h1});
      step(14'h3800, 8'h00);
      ck({pc_ff, busy_ff}, {13'h1924, 1'h0});
      @(posedge clk_sys) upper_jump_latch <= 8'hE7;
      step(14'h2FFF, 8'h00);
      ck(pc_ff, 13'h07FF);
      $display("jump test done");
   endtask
   task t_reset;
      @(posedge clk_sys) rst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      #1;
      ck({acc_ff, zero_flag_ff, squash_ff, busy_ff, file_we_ff}, 12'h000);
      ck(pc_ff, 13'h0000);
      @(posedge clk_sys) rst_n <= 1'h1;
      step(14'h3801, 8'h00);
      ck({acc_ff, pc_ff}, {8'h01, 13'h0001});
      $display("reset test done");
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'h1;
      t_alu;
      t_skip;
      t_jump;
      t_reset;
      end_sim(0);
   end
endmodule
